// ===== scc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Delay bit set: master samples input data one clock later.
// - Bit order bit picks LSB-first when one, MSB-first when zero.
// - Auto-clear bit: buffer or FIFO access clears byte-done flag.
// - DMA wrap: address at end address reloads the start address.
// - DMA enable bit turns DMA address stepping on or off.
// - Enable bit 7 gates the first-byte command interrupt.
// - Enable bit 4 gates the FIFO overflow interrupt.
// - Enable bit 3 gates the DMA done interrupt.
// - Enable bit 2 gates the FIFO half-used interrupt.
// - Enable bit 1 gates the byte-done interrupt.
// - Enable bit 0 gates the transfer-done interrupt.
// - Eight-bit divider resets to 10h; software keeps it at least 2.
// - Master serial clock equals system clock over the divider.
// - Slave returns preset byte first; preset resets to 10h.
// - Eight-bit read/write buffer serves transmit and receive.
// - Byte-done flag sets per byte; writing one clears it.
// - First byte after chip select in command mode sets first flag.
// - Buffer read returns last byte; master buffer write sends it when not busy.
module scc_ctrl (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_fifo_access,
  input  wire logic        i_fifo_ov_evt,
  input  wire logic        i_fifo_half_evt,
  input  wire logic        i_cnt_end_evt,
  input  wire logic        i_dma_step,
  output logic             o_dma_en,
  output logic [15:0]      o_dma_addr,
  output logic             o_irq,
  output logic             o_busy,
  input  wire logic        i_miso,
  input  wire logic        i_slv_sck,
  input  wire logic        i_slv_mosi,
  input  wire logic        i_slv_cs_n,
  output logic             o_sck,
  output logic             o_sck_oe,
  output logic             o_mosi,
  output logic             o_mosi_oe,
  output logic             o_miso,
  output logic             o_miso_oe
);
  import scc_pkg::*;

  logic [7:0]  cfg_r;
  logic [7:0]  ie_r;
  logic [7:0]  div_r;
  logic [7:0]  preset_r;
  logic [7:0]  buf_r;
  logic [7:0]  flag_r;
  logic [7:0]  flag_nxt;
  logic [7:0]  mode_r;
  logic [15:0] dma_beg_r;
  logic [15:0] dma_end_r;
  logic [15:0] dma_now_r;
  logic        irq_r;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic [7:0]  wdat;
  logic        buf_touch;
  logic        eng_start;
  logic        eng_busy;
  logic        eng_done;
  logic        eng_first;
  logic [7:0]  eng_rx;
  logic        dma_hit;
  logic        dma_step_ok;
  logic        slave_mode;
  logic [7:0]  tx_src;

  // address decode, shared by the read path and the slave error
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      SCC_OFS_CFG, SCC_OFS_IE, SCC_OFS_DIV, SCC_OFS_PRESET,
      SCC_OFS_BUF, SCC_OFS_FLAG, SCC_OFS_MODE, SCC_OFS_DMA_BEG,
      SCC_OFS_DMA_END, SCC_OFS_DMA_NOW:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  // apb phases; every access completes in one access cycle
  assign setup  = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite & addr_ok(i_paddr);
  assign rd_acc = i_psel & i_penable & ~i_pwrite & addr_ok(i_paddr);
  assign wdat   = i_pwdata[7:0];
  assign o_pready = i_psel & i_penable;
  assign slave_mode = mode_r[SCC_MODE_SLAVE];

  // software touch of the data buffer, read or write
  assign buf_touch = (wr_acc | rd_acc) & (i_paddr == SCC_OFS_BUF);

  // master byte starts from a buffer write; a write while busy
  // still updates the buffer but cannot restart the shifter
  assign eng_start = wr_acc & (i_paddr == SCC_OFS_BUF)
                     & ~slave_mode & ~eng_busy;
  // the buffer flop updates at the start edge, so pass the new byte
  assign tx_src = eng_start ? wdat : buf_r;

  // read data and error captured in setup so outputs are flops
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_pslverr <= ~addr_ok(i_paddr);
      o_prdata  <= 32'h0000_0000;
      if (!i_pwrite)
      begin
        case (i_paddr)
          SCC_OFS_CFG:     o_prdata[7:0]  <= cfg_r & SCC_CFG_MASK;
          SCC_OFS_IE:      o_prdata[7:0]  <= ie_r & SCC_IRQ_MASK;
          SCC_OFS_DIV:     o_prdata[7:0]  <= div_r;
          SCC_OFS_PRESET:  o_prdata[7:0]  <= preset_r;
          SCC_OFS_BUF:     o_prdata[7:0]  <= buf_r;
          SCC_OFS_FLAG:    o_prdata[7:0]  <= flag_r;
          SCC_OFS_MODE:    o_prdata[7:0]  <= mode_r;
          SCC_OFS_DMA_BEG: o_prdata[15:0] <= dma_beg_r;
          SCC_OFS_DMA_END: o_prdata[15:0] <= dma_end_r;
          SCC_OFS_DMA_NOW: o_prdata[15:0] <= dma_now_r;
          default:         o_prdata       <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration and enable registers, reserved bits held at zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cfg_r  <= SCC_RST_CFG;
      ie_r   <= SCC_RST_IE;
      mode_r <= SCC_RST_MODE;
    end
    else if (wr_acc)
    begin
      if (i_paddr == SCC_OFS_CFG)
        cfg_r <= wdat & SCC_CFG_MASK;
      if (i_paddr == SCC_OFS_IE)
        ie_r <= wdat & SCC_IRQ_MASK;
      if (i_paddr == SCC_OFS_MODE)
        mode_r <= wdat & SCC_MODE_MASK;
    end
  end

  // divider and slave preset byte
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_r    <= SCC_RST_DIV;
      preset_r <= SCC_RST_PRESET;
    end
    else if (wr_acc)
    begin
      if (i_paddr == SCC_OFS_DIV)
        div_r <= wdat;
      if (i_paddr == SCC_OFS_PRESET)
        preset_r <= wdat;
    end
  end

  // one buffer for both directions; a finished exchange wins over
  // a software write in the same cycle, since that byte is newer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      buf_r <= SCC_RST_BUF;
    else if (eng_done)
      buf_r <= eng_rx;
    else if (wr_acc && i_paddr == SCC_OFS_BUF)
      buf_r <= wdat;
  end

  // flag next value: clears first, then events, so a set wins
  always_comb
  begin
    flag_nxt = flag_r;
    if (wr_acc && i_paddr == SCC_OFS_FLAG)
      flag_nxt = flag_r & ~(wdat & SCC_IRQ_MASK);
    if (cfg_r[SCC_CFG_AUTO_CLR] && (buf_touch || i_fifo_access))
      flag_nxt[SCC_IRQ_BYTE] = 1'b0;
    if (eng_done)
      flag_nxt[SCC_IRQ_BYTE] = 1'b1;
    if (eng_first && mode_r[SCC_MODE_CMD] && slave_mode)
      flag_nxt[SCC_IRQ_FIRST] = 1'b1;
    if (i_fifo_ov_evt)
      flag_nxt[SCC_IRQ_FIFO_OV] = 1'b1;
    if (i_fifo_half_evt)
      flag_nxt[SCC_IRQ_FIFO_HF] = 1'b1;
    if (i_cnt_end_evt)
      flag_nxt[SCC_IRQ_CNT] = 1'b1;
    if (dma_step_ok && dma_hit)
      flag_nxt[SCC_IRQ_DMA_DONE] = 1'b1;
  end

  // sticky flags
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      flag_r <= SCC_RST_FLAG;
    else
      flag_r <= flag_nxt;
  end

  // interrupt request: each enable gates its own flag
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      irq_r <= 1'b0;
    else
      irq_r <= (flag_r[SCC_IRQ_FIRST]    & ie_r[SCC_IRQ_FIRST])
             | (flag_r[SCC_IRQ_FIFO_OV]  & ie_r[SCC_IRQ_FIFO_OV])
             | (flag_r[SCC_IRQ_DMA_DONE] & ie_r[SCC_IRQ_DMA_DONE])
             | (flag_r[SCC_IRQ_FIFO_HF]  & ie_r[SCC_IRQ_FIFO_HF])
             | (flag_r[SCC_IRQ_BYTE]     & ie_r[SCC_IRQ_BYTE])
             | (flag_r[SCC_IRQ_CNT]      & ie_r[SCC_IRQ_CNT]);
  end

  assign o_irq = irq_r;

  // dma steps only while enabled; end address is inclusive
  assign dma_step_ok = i_dma_step & cfg_r[SCC_CFG_DMA_EN];
  assign dma_hit     = (dma_now_r == dma_end_r);

  // dma address window and current pointer
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      dma_beg_r <= SCC_RST_DMA;
      dma_end_r <= SCC_RST_DMA;
      dma_now_r <= SCC_RST_DMA;
    end
    else
    begin
      if (wr_acc && i_paddr == SCC_OFS_DMA_BEG)
        dma_beg_r <= i_pwdata[15:0];
      if (wr_acc && i_paddr == SCC_OFS_DMA_END)
        dma_end_r <= i_pwdata[15:0];
      // a new start address also restarts the pointer
      if (wr_acc && i_paddr == SCC_OFS_DMA_BEG)
        dma_now_r <= i_pwdata[15:0];
      else if (dma_step_ok)
      begin
        if (dma_hit && cfg_r[SCC_CFG_DMA_WRAP])
          dma_now_r <= dma_beg_r;
        else
          dma_now_r <= dma_now_r + 16'h0001;
      end
    end
  end

  assign o_dma_en   = cfg_r[SCC_CFG_DMA_EN];
  assign o_dma_addr = dma_now_r;
  assign o_busy     = eng_busy;
  // master drives clock and data; slave lines stay released
  assign o_sck_oe   = ~slave_mode;
  assign o_mosi_oe  = ~slave_mode;

  // serial shifter and clock generator
  scc_shift_engine u_engine (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_slave_mode (slave_mode),
    .i_lsb_first  (cfg_r[SCC_CFG_LSB_FIRST]),
    .i_in_delay   (cfg_r[SCC_CFG_IN_DLY]),
    .i_div        (div_r),
    .i_start      (eng_start),
    .i_tx_byte    (tx_src),
    .i_preset     (preset_r),
    .i_miso       (i_miso),
    .i_slv_sck    (i_slv_sck),
    .i_slv_mosi   (i_slv_mosi),
    .i_slv_cs_n   (i_slv_cs_n),
    .o_sck        (o_sck),
    .o_mosi       (o_mosi),
    .o_miso       (o_miso),
    .o_miso_oe    (o_miso_oe),
    .o_busy       (eng_busy),
    .o_byte_done  (eng_done),
    .o_first_byte (eng_first),
    .o_rx_byte    (eng_rx)
  );

endmodule : scc_ctrl
`default_nettype wire

// ===== scc_pkg.sv
package scc_pkg;

  // apb byte addresses, one aligned word per register
  localparam logic [7:0] SCC_OFS_CFG     = 8'h00;
  localparam logic [7:0] SCC_OFS_IE      = 8'h04;
  localparam logic [7:0] SCC_OFS_DIV     = 8'h08;
  localparam logic [7:0] SCC_OFS_PRESET  = 8'h0C;
  localparam logic [7:0] SCC_OFS_BUF     = 8'h10;
  localparam logic [7:0] SCC_OFS_FLAG    = 8'h14;
  localparam logic [7:0] SCC_OFS_MODE    = 8'h18;
  localparam logic [7:0] SCC_OFS_DMA_BEG = 8'h1C;
  localparam logic [7:0] SCC_OFS_DMA_END = 8'h20;
  localparam logic [7:0] SCC_OFS_DMA_NOW = 8'h24;

  // configuration fields
  localparam int SCC_CFG_IN_DLY    = 6;
  localparam int SCC_CFG_LSB_FIRST = 5;
  localparam int SCC_CFG_AUTO_CLR  = 4;
  localparam int SCC_CFG_DMA_WRAP  = 2;
  localparam int SCC_CFG_DMA_EN    = 0;
  localparam logic [7:0] SCC_CFG_MASK  = 8'h75;

  // interrupt enable and flag fields share positions
  localparam int SCC_IRQ_FIRST    = 7;
  localparam int SCC_IRQ_FIFO_OV  = 4;
  localparam int SCC_IRQ_DMA_DONE = 3;
  localparam int SCC_IRQ_FIFO_HF  = 2;
  localparam int SCC_IRQ_BYTE     = 1;
  localparam int SCC_IRQ_CNT      = 0;
  localparam logic [7:0] SCC_IRQ_MASK  = 8'h9F;

  // mode fields
  localparam int SCC_MODE_SLAVE    = 0;
  localparam int SCC_MODE_CMD      = 3;
  localparam logic [7:0] SCC_MODE_MASK = 8'h09;

  // reset values
  localparam logic [7:0]  SCC_RST_CFG    = 8'h00;
  localparam logic [7:0]  SCC_RST_IE     = 8'h00;
  localparam logic [7:0]  SCC_RST_DIV    = 8'h10;
  localparam logic [7:0]  SCC_RST_PRESET = 8'h10;
  localparam logic [7:0]  SCC_RST_BUF    = 8'h00;
  localparam logic [7:0]  SCC_RST_FLAG   = 8'h01;
  localparam logic [7:0]  SCC_RST_MODE   = 8'h00;
  localparam logic [15:0] SCC_RST_DMA    = 16'h0000;

  // smallest legal division factor
  localparam logic [7:0] SCC_DIV_MIN = 8'h02;

  // master serial clock phases, gray along idle-low-high
  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'b00,
    SCC_ST_LOW  = 2'b01,
    SCC_ST_HIGH = 2'b11
  } scc_state_e;

endpackage : scc_pkg

// ===== scc_shift_engine.sv
`timescale 1ns/1ps
`default_nettype none
module scc_shift_engine (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slave_mode,
  input  wire logic       i_lsb_first,
  input  wire logic       i_in_delay,
  input  wire logic [7:0] i_div,
  input  wire logic       i_start,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic [7:0] i_preset,
  input  wire logic       i_miso,
  input  wire logic       i_slv_sck,
  input  wire logic       i_slv_mosi,
  input  wire logic       i_slv_cs_n,
  output logic            o_sck,
  output logic            o_mosi,
  output logic            o_miso,
  output logic            o_miso_oe,
  output logic            o_busy,
  output logic            o_byte_done,
  output logic            o_first_byte,
  output logic [7:0]      o_rx_byte
);
  import scc_pkg::*;

  scc_state_e  state_r;
  logic [7:0]  cnt_r;
  logic [2:0]  bit_r;
  logic [7:0]  tx_r;
  logic [7:0]  rx_r;
  logic        samp_pend_r;
  logic        fin_r;
  logic        sck_prev_r;
  logic        cs_prev_r;
  logic        first_pend_r;
  logic [7:0]  div_eff;
  logic [7:0]  hi_len;
  logic [7:0]  lo_len;
  logic        m_sample;
  logic        s_rise;
  logic        s_fall;
  logic        s_sel;

  // insert one received bit on the side chosen by the bit order
  function automatic logic [7:0] ins_bit(input logic [7:0] sh,
                                         input logic b,
                                         input logic lsb);
    ins_bit = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : ins_bit

  // shift out the sent bit, same order
  function automatic logic [7:0] adv_tx(input logic [7:0] sh,
                                        input logic lsb);
    adv_tx = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  endfunction : adv_tx

  // an illegal factor below two would give a zero high phase
  assign div_eff = (i_div < SCC_DIV_MIN) ? SCC_DIV_MIN : i_div;
  assign hi_len  = div_eff >> 1;
  assign lo_len  = div_eff - hi_len;
  assign s_sel   = i_slave_mode & ~i_slv_cs_n;
  assign s_rise  = s_sel & i_slv_sck & ~sck_prev_r;
  assign s_fall  = s_sel & ~i_slv_sck & sck_prev_r;
  // sample at the rising edge, or one system clock later
  assign m_sample = i_in_delay ? samp_pend_r
                  : (state_r == SCC_ST_LOW && cnt_r == lo_len - 8'd1);

  // master phase sequencer: low for lo_len, high for hi_len
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_r <= SCC_ST_IDLE;
      cnt_r   <= 8'h00;
      bit_r   <= 3'd0;
      fin_r   <= 1'b0;
    end
    else
    begin
      fin_r <= 1'b0;
      case (state_r)
        SCC_ST_IDLE:
        begin
          if (i_start && !i_slave_mode)
          begin
            state_r <= SCC_ST_LOW;
            cnt_r   <= 8'h00;
            bit_r   <= 3'd0;
          end
          // slave counts its own rising edges, restarting per select
          else if (i_slave_mode && cs_prev_r && !i_slv_cs_n)
            bit_r <= 3'd0;
          else if (s_rise)
            bit_r <= bit_r + 3'd1;
        end
        SCC_ST_LOW:
        begin
          if (cnt_r == lo_len - 8'd1)
          begin
            state_r <= SCC_ST_HIGH;
            cnt_r   <= 8'h00;
          end
          else
            cnt_r <= cnt_r + 8'd1;
        end
        SCC_ST_HIGH:
        begin
          if (cnt_r == hi_len - 8'd1)
          begin
            cnt_r <= 8'h00;
            bit_r <= bit_r + 3'd1;
            if (bit_r == 3'd7)
            begin
              state_r <= SCC_ST_IDLE;
              fin_r   <= 1'b1;
            end
            else
              state_r <= SCC_ST_LOW;
          end
          else
            cnt_r <= cnt_r + 8'd1;
        end
        default: state_r <= SCC_ST_IDLE;
      endcase
    end
  end

  // delayed sample request, taken one clock after the rising edge
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      samp_pend_r <= 1'b0;
    else
      samp_pend_r <= (state_r == SCC_ST_LOW)
                     && (cnt_r == lo_len - 8'd1);
  end

  // edge history of the slave pins
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
    end
    else
    begin
      sck_prev_r <= i_slv_sck;
      cs_prev_r  <= i_slv_cs_n;
    end
  end

  // transmit and receive shift registers for both roles
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tx_r         <= 8'h00;
      rx_r         <= 8'h00;
      first_pend_r <= 1'b0;
    end
    else if (i_slave_mode)
    begin
      if (cs_prev_r && !i_slv_cs_n)
      begin
        tx_r         <= i_preset;
        first_pend_r <= 1'b1;
      end
      else if (s_rise)
      begin
        rx_r <= ins_bit(rx_r, i_slv_mosi, i_lsb_first);
        if (bit_r == 3'd7)
          first_pend_r <= 1'b0;
      end
      else if (s_fall)
        tx_r <= (bit_r == 3'd0) ? i_tx_byte
                                : adv_tx(tx_r, i_lsb_first);
    end
    else
    begin
      if (state_r == SCC_ST_IDLE && i_start)
        tx_r <= i_tx_byte;
      else if (state_r == SCC_ST_HIGH && cnt_r == hi_len - 8'd1)
        tx_r <= adv_tx(tx_r, i_lsb_first);
      if (m_sample)
        rx_r <= ins_bit(rx_r, i_miso, i_lsb_first);
    end
  end

  // completion pulses and received byte; slave reuses bit_r
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_byte_done  <= 1'b0;
      o_first_byte <= 1'b0;
      o_rx_byte    <= 8'h00;
    end
    else
    begin
      o_byte_done  <= fin_r | (s_rise && bit_r == 3'd7);
      o_first_byte <= s_rise && bit_r == 3'd7 && first_pend_r;
      if (fin_r)
        o_rx_byte <= rx_r;
      else if (s_rise && bit_r == 3'd7)
        o_rx_byte <= ins_bit(rx_r, i_slv_mosi, i_lsb_first);
    end
  end

  // pins: mode0, clock idles low
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_sck     <= 1'b0;
      o_mosi    <= 1'b0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      o_sck     <= (state_r == SCC_ST_HIGH);
      o_mosi    <= i_lsb_first ? tx_r[0] : tx_r[7];
      o_miso    <= i_lsb_first ? tx_r[0] : tx_r[7];
      o_miso_oe <= s_sel;
    end
  end

  assign o_busy = (state_r != SCC_ST_IDLE) | fin_r;

endmodule : scc_shift_engine
`default_nettype wire

// ===== scc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scc_monitor
  import scc_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        i_dma_step,
  input wire logic        o_dma_en,
  input wire logic [15:0] o_dma_addr,
  input wire logic        o_irq,
  input wire logic        o_busy,
  input wire logic        o_sck,
  input wire logic        o_sck_oe,
  input wire logic        o_miso_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic       acc;
  logic       rd_setup;
  logic       sck_q;
  logic       seen_r;
  logic [8:0] cnt_r;
  logic [7:0] div_r;
  assign acc = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  // shadow divider; spacing of sck rises, only inside one busy stretch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_r  <= SCC_RST_DIV;
      sck_q  <= 1'b0;
      seen_r <= 1'b0;
      cnt_r  <= 9'h000;
    end
    else
    begin
      sck_q <= o_sck;
      if (acc && i_paddr == SCC_OFS_DIV)
        div_r <= i_pwdata[7:0];
      cnt_r  <= (o_sck & ~sck_q) ? 9'h001 : cnt_r + 9'h001;
      seen_r <= ~o_busy ? 1'b0 : ((o_sck & ~sck_q) | seen_r);
    end
  end
  property p_cfg_rsv;
    rd_setup && i_paddr == SCC_OFS_CFG |=> (o_prdata & ~32'h0000_0075) == '0;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv)
    else $error("cfg reserved bits");
  property p_ie_rsv;
    rd_setup && i_paddr == SCC_OFS_IE |=> (o_prdata & ~32'h0000_009F) == '0;
  endproperty
  a_ie_rsv: assert property (p_ie_rsv)
    else $error("ie reserved bits");
  property p_dma_en;
    acc && i_paddr == SCC_OFS_CFG |=> o_dma_en == $past(i_pwdata[0]);
  endproperty
  a_dma_en: assert property (p_dma_en)
    else $error("dma enable wrong");
  property p_dma_hold;
    i_dma_step && !o_dma_en && !acc |=> $stable(o_dma_addr);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("dma moved while off");
  property p_irq_off;
    acc && i_paddr == SCC_OFS_IE && i_pwdata[7:0] == 8'h00 |=> ##1 !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq with no enable");
  property p_sck_idle;
    !o_busy [*2] |-> !o_sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("sck not idle low");
  property p_miso_oe;
    o_miso_oe |-> !o_sck_oe;
  endproperty
  a_miso_oe: assert property (p_miso_oe)
    else $error("miso driven in master");
  property p_sck_per;
    o_sck && !sck_q && seen_r |-> cnt_r == {1'b0, div_r};
  endproperty
  a_sck_per: assert property (p_sck_per)
    else $error("sck period not div");
endmodule : scc_monitor
bind scc_ctrl scc_monitor i_scc_monitor (.*);
`default_nettype wire

// ===== scc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module scc_peer_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_load,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx,
  output logic [8:0]      o_per
);
  logic [3:0] fall_r = 4'h8;
  logic       sck_q  = 1'b0;
  logic [8:0] cyc_r  = 9'h000;
  // falls counted from load; bits leave msb first in mode 0
  always @(negedge i_sck or posedge i_load)
  begin
    if (i_load)
      fall_r <= 4'h0;
    else
      fall_r <= fall_r + 4'h1;
  end
  // rise spacing in system clocks; mosi taken msb first one clock
  // after sck rises, since both pins leave the same flop edge
  always @(posedge i_ref_clk)
  begin
    sck_q <= i_sck;
    cyc_r <= (i_sck && !sck_q) ? 9'h001 : cyc_r + 9'h001;
    if (i_sck && !sck_q)
    begin
      o_per <= cyc_r;
      o_rx  <= {o_rx[6:0], i_mosi};
    end
  end
  // after the byte the line toggles, so a stale sample cannot pass
  assign o_miso = (fall_r < 4'h8) ? i_tx[3'h7 - fall_r[2:0]] : cyc_r[0];
endmodule : scc_peer_model
`default_nettype wire

// ===== scc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module scc_ctrl_test
  import scc_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = '0;
  logic        i_fifo_access = 1'b0, i_dma_step = 1'b0;
  logic        i_fifo_ov_evt = 1'b0, i_fifo_half_evt = 1'b0;
  logic        i_cnt_end_evt = 1'b0;
  logic        i_slv_sck = 1'b0, i_slv_mosi = 1'b0, i_slv_cs_n = 1'b1;
  logic        i_miso;
  logic [31:0] o_prdata, rdat;
  logic [15:0] o_dma_addr;
  logic        o_pready, o_pslverr, o_dma_en, o_irq, o_busy, perr;
  logic        o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe;
  logic        peer_load = 1'b0;
  logic [7:0]  peer_tx = 8'h00, peer_rx, tx;
  logic [8:0]  peer_per;
  logic [7:0]  dv [4] = '{8'h02, 8'h04, 8'h07, 8'h10};
  logic [7:0]  cf [4] = '{8'h40, 8'h20, 8'h60, 8'h30};
  logic [7:0]  ev [3] = '{8'h10, 8'h04, 8'h01};
  int          err_total = 0, tests_run = 0, seed = 42415;
  scc_ctrl i_scc_ctrl (.*);
  scc_peer_model i_scc_peer_model (.i_ref_clk(i_ref_clk), .i_sck(o_sck),
    .i_mosi(o_mosi), .i_load(peer_load), .i_tx(peer_tx), .o_miso(i_miso),
    .o_rx(peer_rx), .o_per(peer_per));
  // 200 MHz system clock
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      rev[k] = v[7-k];
  endfunction : rev
  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    rdat = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rdat, e);
  endtask : rchk
  // hang guard, well above the expected run length
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    stop_test();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rchk(SCC_OFS_CFG, '0);
    rchk(SCC_OFS_DIV, 32'h0000_0010);
    rchk(SCC_OFS_PRESET, 32'h0000_0010);
    apb(1'b1, SCC_OFS_CFG, '1);
    rchk(SCC_OFS_CFG, 32'h0000_0075);
    apb(1'b1, SCC_OFS_IE, '1);
    rchk(SCC_OFS_IE, 32'h0000_009F);
    apb(1'b1, 8'h40, '1);
    chk(perr, 1'b1);
    tx = 8'($random(seed));
    apb(1'b1, SCC_OFS_PRESET, {24'h0, tx});
    rchk(SCC_OFS_PRESET, {24'h0, tx});
    apb(1'b1, SCC_OFS_IE, 32'h0000_0002);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, SCC_OFS_DIV, {24'h0, dv[i]});
      apb(1'b1, SCC_OFS_CFG, {24'h0, cf[i]});
      peer_tx <= 8'($random(seed));
      peer_load <= 1'b1;
      @(posedge i_ref_clk);
      peer_load <= 1'b0;
      tx = 8'($random(seed));
      apb(1'b1, SCC_OFS_BUF, {24'h0, tx});
      repeat (2) @(posedge i_ref_clk);
      while (o_busy === 1'b1) @(posedge i_ref_clk);
      repeat (3) @(posedge i_ref_clk);
      chk(o_irq, 1'b1);
      chk(peer_rx, cf[i][5] ? rev(tx) : tx);
      chk(peer_per, dv[i]);
      apb(1'b0, SCC_OFS_FLAG, '0);
      chk(rdat & 32'h0000_0002, 32'h0000_0002);
      rchk(SCC_OFS_BUF, cf[i][5] ? rev(peer_tx) : peer_tx);
      if (!cf[i][4])
        apb(1'b1, SCC_OFS_FLAG, 32'h0000_0002);
      apb(1'b0, SCC_OFS_FLAG, '0);
      chk(rdat & 32'h0000_0002, '0);
      chk(o_irq, 1'b0);
    end
    apb(1'b1, SCC_OFS_IE, '0);
    for (int k = 0; k < 3; k++)
    begin
      {i_fifo_ov_evt, i_fifo_half_evt, i_cnt_end_evt} <= 3'b100 >> k;
      @(posedge i_ref_clk);
      {i_fifo_ov_evt, i_fifo_half_evt, i_cnt_end_evt} <= 3'b000;
      repeat (3) @(posedge i_ref_clk);
      chk(o_irq, 1'b0);
      apb(1'b1, SCC_OFS_IE, {24'h0, ev[k]});
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 1'b1);
      apb(1'b1, SCC_OFS_FLAG, {24'h0, ev[k]});
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 1'b0);
      apb(1'b1, SCC_OFS_IE, '0);
    end
    apb(1'b1, SCC_OFS_DMA_BEG, 32'h0000_0100);
    apb(1'b1, SCC_OFS_DMA_END, 32'h0000_0102);
    apb(1'b1, SCC_OFS_CFG, 32'h0000_0005);
    @(posedge i_ref_clk);
    chk(o_dma_en, 1'b1);
    // three steps reach the end address and wrap
    repeat (3)
    begin
      i_dma_step <= 1'b1;
      @(posedge i_ref_clk);
      i_dma_step <= 1'b0;
      @(posedge i_ref_clk);
    end
    rchk(SCC_OFS_DMA_NOW, 32'h0000_0100);
    apb(1'b0, SCC_OFS_FLAG, '0);
    chk(rdat & 32'h0000_0008, 32'h0000_0008);
    apb(1'b1, SCC_OFS_CFG, '0);
    i_dma_step <= 1'b1;
    @(posedge i_ref_clk);
    i_dma_step <= 1'b0;
    rchk(SCC_OFS_DMA_NOW, 32'h0000_0100);
    // slave, command mode: preset goes out while a byte comes in
    tx = 8'($random(seed));
    apb(1'b1, SCC_OFS_PRESET, {24'h0, tx});
    apb(1'b1, SCC_OFS_MODE, 32'h0000_0009);
    peer_tx <= 8'($random(seed));
    i_slv_cs_n <= 1'b0;
    for (int b = 7; b >= 0; b--)
    begin
      repeat (3) @(posedge i_ref_clk);
      chk(o_miso, tx[b]);
      i_slv_mosi <= peer_tx[b];
      i_slv_sck <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_slv_sck <= 1'b0;
    end
    repeat (3) @(posedge i_ref_clk);
    chk({o_sck_oe, o_mosi_oe, o_miso_oe}, 3'b001);
    i_slv_cs_n <= 1'b1;
    apb(1'b0, SCC_OFS_FLAG, '0);
    chk(rdat & 32'h0000_0082, 32'h0000_0082);
    rchk(SCC_OFS_BUF, peer_tx);
    stop_test();
  end
endmodule : scc_ctrl_test
`default_nettype wire
